// ===== logic/port_op_pkg.sv
package port_op_pkg;

  // Register map
  localparam logic [15:0] ADDR_PORT_OPERATION_CONTROL = 16'h0020;
  localparam logic [15:0] ADDR_PORT_LINK_STATUS       = 16'h0030;

  // Control register fields
  localparam int CTRL_LOCAL_LOOP_BIT  = 7;
  localparam int CTRL_REMOTE_LOOP_BIT = 6;
  localparam int CTRL_TAIL_TAG_BIT    = 2;
  localparam int CTRL_SPLIT_LSB       = 0;
  localparam int CTRL_SPLIT_MSB       = 1;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'hC7;
  localparam logic [7:0] CTRL_RESET      = 8'h00;

  // Status register fields
  localparam int STAT_SPEED_LSB  = 3;
  localparam int STAT_SPEED_MSB  = 4;
  localparam int STAT_DUPLEX_BIT = 2;
  localparam int STAT_TX_FC_BIT  = 1;
  localparam int STAT_RX_FC_BIT  = 0;
  localparam logic [7:0] STAT_RESET = 8'h04;

  // Pause advertisement field of the transceiver
  localparam int ADV_PAUSE_LSB = 10;
  localparam int ADV_PAUSE_MSB = 11;

  // Egress queue split codes
  localparam logic [1:0] SPLIT_ONE  = 2'h0;
  localparam logic [1:0] SPLIT_TWO  = 2'h1;
  localparam logic [1:0] SPLIT_FOUR = 2'h2;

  // Speed codes
  localparam logic [1:0] SPEED_10   = 2'h0;
  localparam logic [1:0] SPEED_100  = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;

  // Synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 2;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } beat_s;

  typedef struct packed {
    logic speed_1g;
    logic speed_100;
    logic duplex;
    logic tx_fc_en;
    logic rx_fc_en;
  } mac_cfg_s;

  typedef struct packed {
    logic        link_up;
    logic [1:0]  speed;
    logic        duplex;
    logic [15:0] advert;
    logic        an_tx_fc;
    logic        an_rx_fc;
  } phy_res_s;

  typedef enum logic [1:0] {
    PATH_NORMAL,
    PATH_LOCAL,
    PATH_REMOTE,
    PATH_BOTH
  } loop_path_e;

endpackage

// ===== logic/sync_two_flop.sv
`timescale 1ns/1ps
module sync_two_flop #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule

// ===== logic/port_operation_control_status.sv
// Summary of operation
// - Bit 7 loops fabric egress back to fabric
// - Bit 6 loops pin ingress back out pins
// - Transceiver port: line receive retransmitted on transmit
// - MAC port: transmit inputs driven onto receive outputs
// - Bit 2 enables tail tag, marks host port
// - Split field: 00 one, 01 two, 10 four
// - Multi-queue maps by priority; single ignores priority
// - Status 4:3 speed; MAC mirrors configured speed
// - Transceiver speed status shows resolved link speed
// - Status 2 duplex; MAC mirrors configured duplex
// - Transceiver duplex status shows link duplex
// - Status 1 transmit flow control; MAC copies enable
// - Status 0 receive flow control; MAC copies enable
// - Transceiver flow control needs pause, link, agreement
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module port_operation_control_status #(
  parameter bit PHY_PORT = 1'b1
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rstn,
  input  wire logic [15:0]            addr_i,
  input  wire logic [7:0]             wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [7:0]             rdata_r,
  input  wire port_op_pkg::beat_s     fabric_egress_i,
  input  wire logic [2:0]             egress_prio_i,
  output port_op_pkg::beat_s          fabric_ingress_r,
  output port_op_pkg::beat_s          pin_egress_r,
  input  wire port_op_pkg::beat_s     pin_ingress_i,
  output logic      [1:0]             queue_sel_r,
  output logic                        tail_tag_en_r,
  output logic      [1:0]             queue_split_r,
  output logic                        local_loop_r,
  output logic                        remote_loop_r,
  input  wire port_op_pkg::mac_cfg_s  mac_cfg_i,
  input  wire port_op_pkg::phy_res_s  phy_res_i
);
  import port_op_pkg::*;

  logic [7:0] ctrl_r;
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  beat_s      pin_sync;
  loop_path_e path;
  logic       wr_ctrl;
  logic       rd_hit;

  function automatic logic [1:0] queue_of(input logic [1:0] split, input logic [2:0] prio);
    logic [1:0] q;
    q = 2'h0;
    unique case (split)
      SPLIT_TWO:  q = {1'b0, prio[2]};
      SPLIT_FOUR: q = prio[2:1];
      default:    q = 2'h0;
    endcase
    return q;
  endfunction

  function automatic logic [1:0] mac_speed(input mac_cfg_s cfg);
    logic [1:0] s;
    s = SPEED_10;
    if (cfg.speed_1g) begin
      s = SPEED_1000;
    end else if (cfg.speed_100) begin
      s = SPEED_100;
    end
    return s;
  endfunction

  // Pin data crosses in from outside the clock domain
  sync_two_flop #(
    .WIDTH ($bits(beat_s))
  ) u_pin_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .async_i (pin_ingress_i),
    .sync_o  (pin_sync)
  );

  assign wr_ctrl = wr_i && (addr_i == ADDR_PORT_OPERATION_CONTROL);
  assign rd_hit  = (addr_i == ADDR_PORT_OPERATION_CONTROL) || (addr_i == ADDR_PORT_LINK_STATUS);
  assign path    = loop_path_e'({ctrl_r[CTRL_REMOTE_LOOP_BIT], ctrl_r[CTRL_LOCAL_LOOP_BIT]});

  // Control register, reserved bits never stored
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= wdata_i & CTRL_WRITE_MASK;
    end
  end

  // Register read, one cycle later
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 8'h00;
    end else if (rd_i && rd_hit) begin
      rdata_r <= (addr_i == ADDR_PORT_OPERATION_CONTROL) ? ctrl_r : status_r;
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // Control outputs
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tail_tag_en_r <= 1'b0;
      queue_split_r <= SPLIT_ONE;
      local_loop_r  <= 1'b0;
      remote_loop_r <= 1'b0;
    end else begin
      tail_tag_en_r <= wr_ctrl ? wdata_i[CTRL_TAIL_TAG_BIT] : ctrl_r[CTRL_TAIL_TAG_BIT];
      queue_split_r <= wr_ctrl ? wdata_i[CTRL_SPLIT_MSB:CTRL_SPLIT_LSB]
                               : ctrl_r[CTRL_SPLIT_MSB:CTRL_SPLIT_LSB];
      local_loop_r  <= wr_ctrl ? wdata_i[CTRL_LOCAL_LOOP_BIT] : ctrl_r[CTRL_LOCAL_LOOP_BIT];
      remote_loop_r <= wr_ctrl ? wdata_i[CTRL_REMOTE_LOOP_BIT] : ctrl_r[CTRL_REMOTE_LOOP_BIT];
    end
  end

  // Egress queue selection by priority
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      queue_sel_r <= 2'h0;
    end else begin
      queue_sel_r <= queue_of(ctrl_r[CTRL_SPLIT_MSB:CTRL_SPLIT_LSB], egress_prio_i);
    end
  end

  // Datapath steering toward the fabric and the pins
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fabric_ingress_r <= '0;
      pin_egress_r     <= '0;
    end else begin
      unique case (path)
        PATH_NORMAL: begin
          fabric_ingress_r <= pin_sync;
          pin_egress_r     <= fabric_egress_i;
        end
        PATH_LOCAL: begin
          fabric_ingress_r <= fabric_egress_i;
          pin_egress_r     <= '0;
        end
        PATH_REMOTE: begin
          fabric_ingress_r <= '0;
          pin_egress_r     <= pin_sync;
        end
        PATH_BOTH: begin
          fabric_ingress_r <= fabric_egress_i;
          pin_egress_r     <= pin_sync;
        end
      endcase
    end
  end

  // Status value from the port's own source
  always_comb begin
    status_nxt = 8'h00;
    if (PHY_PORT) begin
      status_nxt[STAT_SPEED_MSB:STAT_SPEED_LSB] = phy_res_i.speed;
      status_nxt[STAT_DUPLEX_BIT] = phy_res_i.duplex;
      status_nxt[STAT_TX_FC_BIT] = phy_res_i.link_up && phy_res_i.an_tx_fc
        && (phy_res_i.advert[ADV_PAUSE_MSB:ADV_PAUSE_LSB] != 2'h0);
      status_nxt[STAT_RX_FC_BIT] = phy_res_i.link_up && phy_res_i.an_rx_fc
        && (phy_res_i.advert[ADV_PAUSE_MSB:ADV_PAUSE_LSB] != 2'h0);
    end else begin
      status_nxt[STAT_SPEED_MSB:STAT_SPEED_LSB] = mac_speed(mac_cfg_i);
      status_nxt[STAT_DUPLEX_BIT] = mac_cfg_i.duplex;
      status_nxt[STAT_TX_FC_BIT]  = mac_cfg_i.tx_fc_en;
      status_nxt[STAT_RX_FC_BIT]  = mac_cfg_i.rx_fc_en;
    end
  end

  // Status register, not writable
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      status_r <= STAT_RESET;
    end else begin
      status_r <= status_nxt;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  chk_local_loop_path: assert property (
    (ctrl_r[CTRL_LOCAL_LOOP_BIT] && !wr_ctrl)
      |=> fabric_ingress_r == $past(fabric_egress_i))
    else $error("local loopback did not return fabric data");

  chk_remote_loop_pins: assert property (
    (ctrl_r[CTRL_REMOTE_LOOP_BIT] && !wr_ctrl && $past(rstn, 2))
      |=> pin_egress_r == $past(pin_ingress_i, 3))
    else $error("remote loopback did not return pin data");

  chk_phy_remote_loop: assert property (
    (PHY_PORT && ctrl_r[CTRL_REMOTE_LOOP_BIT]) |=> pin_egress_r == $past(pin_sync))
    else $error("transceiver remote loopback mismatch");

  chk_mac_remote_loop: assert property (
    (!PHY_PORT && ctrl_r[CTRL_REMOTE_LOOP_BIT]) |=> pin_egress_r == $past(pin_sync))
    else $error("interface remote loopback mismatch");

  chk_tail_tag_write: assert property (
    wr_ctrl |=> tail_tag_en_r == $past(wdata_i[CTRL_TAIL_TAG_BIT]))
    else $error("tail tag enable not following write");

  chk_split_write: assert property (
    wr_ctrl |=> queue_split_r == $past(wdata_i[CTRL_SPLIT_MSB:CTRL_SPLIT_LSB]) ##1
      queue_split_r == ctrl_r[CTRL_SPLIT_MSB:CTRL_SPLIT_LSB] || $past(wr_ctrl))
    else $error("queue split not following write");

  chk_single_queue: assert property (
    (ctrl_r[CTRL_SPLIT_MSB:CTRL_SPLIT_LSB] == SPLIT_ONE) |=> queue_sel_r == 2'h0)
    else $error("single queue produced nonzero queue");

  chk_four_queue_map: assert property (
    (ctrl_r[CTRL_SPLIT_MSB:CTRL_SPLIT_LSB] == SPLIT_FOUR)
      |=> queue_sel_r == $past(egress_prio_i[2:1]))
    else $error("four queue mapping wrong");

  chk_mac_speed_mirror: assert property (
    !PHY_PORT |=> status_r[STAT_SPEED_MSB:STAT_SPEED_LSB]
      == ($past(mac_cfg_i.speed_1g) ? SPEED_1000
          : ($past(mac_cfg_i.speed_100) ? SPEED_100 : SPEED_10)))
    else $error("interface speed status mismatch");

  chk_phy_speed_duplex: assert property (
    PHY_PORT |=> status_r[STAT_SPEED_MSB:STAT_DUPLEX_BIT]
      == $past({phy_res_i.speed, phy_res_i.duplex}))
    else $error("transceiver speed or duplex status mismatch");

  chk_mac_duplex_fc: assert property (
    !PHY_PORT |=> status_r[STAT_DUPLEX_BIT:STAT_RX_FC_BIT]
      == $past({mac_cfg_i.duplex, mac_cfg_i.tx_fc_en, mac_cfg_i.rx_fc_en}))
    else $error("interface duplex or flow control status mismatch");

  chk_phy_fc_cause: assert property (
    (PHY_PORT && (status_r[STAT_TX_FC_BIT] || status_r[STAT_RX_FC_BIT]))
      |-> $past(phy_res_i.link_up)
          && $past(phy_res_i.advert[ADV_PAUSE_MSB:ADV_PAUSE_LSB]) != 2'h0)
    else $error("flow control status without pause and link");

  chk_reserved_read: assert property (
    (rd_i && addr_i == ADDR_PORT_OPERATION_CONTROL) |=> rdata_r[5:3] == 3'h0)
    else $error("reserved control bits read nonzero");

  chk_status_read: assert property (
    (rd_i && addr_i == ADDR_PORT_LINK_STATUS)
      |=> rdata_r == $past(status_r) && rdata_r[7:5] == 3'h0)
    else $error("status read value wrong");

endmodule

// ===== sim/test_port_operation_control_status.sv
`timescale 1ns/1ps
module test_port_operation_control_status;
  import port_op_pkg::*;
  typedef struct {
    logic [7:0] wv;
    logic [2:0] prio;
    phy_res_s   phy;
    mac_cfg_s   mac;
    logic [7:0] ec;
    logic [1:0] eq;
    logic [7:0] esp;
    logic [7:0] esm;
  } row_s;
  localparam beat_s fab_b = '{1'b1, 8'hA5};
  localparam beat_s pin_b = '{1'b1, 8'h3C};
  localparam beat_s nil_b = '0;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [7:0]  rdata_r;
  logic [7:0]  m_rdata;
  beat_s       fabric_egress_i = '0;
  logic [2:0]  egress_prio_i = 3'h0;
  beat_s       fabric_ingress_r;
  beat_s       pin_egress_r;
  beat_s       pin_ingress_i = '0;
  logic [1:0]  queue_sel_r;
  logic [1:0]  queue_split_r;
  logic        tail_tag_en_r;
  logic        local_loop_r;
  logic        remote_loop_r;
  mac_cfg_s    mac_cfg_i = '0;
  phy_res_s    phy_res_i = '0;
  int          bad_count = 0;
  int          total_checks = 0;
  row_s        rows [4];

  always #12.5 sys_clk = ~sys_clk;

  port_operation_control_status #(.PHY_PORT(1'b1)) dut (
    .sys_clk(sys_clk), .rstn(rstn), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_r(rdata_r), .fabric_egress_i(fabric_egress_i),
    .egress_prio_i(egress_prio_i), .fabric_ingress_r(fabric_ingress_r),
    .pin_egress_r(pin_egress_r), .pin_ingress_i(pin_ingress_i), .queue_sel_r(queue_sel_r),
    .tail_tag_en_r(tail_tag_en_r), .queue_split_r(queue_split_r),
    .local_loop_r(local_loop_r), .remote_loop_r(remote_loop_r), .mac_cfg_i(mac_cfg_i),
    .phy_res_i(phy_res_i));

  port_operation_control_status #(.PHY_PORT(1'b0)) dut_mac (
    .sys_clk(sys_clk), .rstn(rstn), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_r(m_rdata), .fabric_egress_i(fabric_egress_i),
    .egress_prio_i(egress_prio_i), .fabric_ingress_r(), .pin_egress_r(),
    .pin_ingress_i(pin_ingress_i), .queue_sel_r(), .tail_tag_en_r(), .queue_split_r(),
    .local_loop_r(), .remote_loop_r(), .mac_cfg_i(mac_cfg_i), .phy_res_i(phy_res_i));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task stop_test;
    if (bad_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk);
    wr_i <= 1'b0;
  endtask

  task rd(input logic [15:0] a, output logic [7:0] p, output logic [7:0] m);
    @(posedge sys_clk);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk);
    rd_i <= 1'b0;
    #1;
    p = rdata_r;
    m = m_rdata;
  endtask

  // One-cycle beats on both sources; fabric side after 1 edge, pin side after 3
  task path(input logic [7:0] c, input beat_s fi1, pe1, fi3, pe3);
    wr(ADDR_PORT_OPERATION_CONTROL, c);
    @(posedge sys_clk);
    fabric_egress_i <= fab_b;
    pin_ingress_i <= pin_b;
    @(posedge sys_clk);
    fabric_egress_i <= nil_b;
    pin_ingress_i <= nil_b;
    #1;
    chk(fabric_ingress_r, fi1);
    chk(pin_egress_r, pe1);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(fabric_ingress_r, fi3);
    chk(pin_egress_r, pe3);
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    stop_test;
  end

  initial begin
    logic [7:0] p;
    logic [7:0] m;
    rows[0] = '{8'hFF, 3'h0, '{1'b1, 2'h2, 1'b1, 16'h0C00, 1'b1, 1'b1}, 5'b11011,
                8'hC7, 2'h0, 8'h17, 8'h13};
    rows[1] = '{8'h01, 3'h5, '{1'b0, 2'h1, 1'b0, 16'h0400, 1'b1, 1'b1}, 5'b01100,
                8'h01, 2'h1, 8'h08, 8'h0C};
    rows[2] = '{8'h02, 3'h6, '{1'b1, 2'h0, 1'b1, 16'h0000, 1'b1, 1'b1}, 5'b00001,
                8'h02, 2'h3, 8'h04, 8'h01};
    rows[3] = '{8'h7C, 3'h7, '{1'b1, 2'h1, 1'b0, 16'h0800, 1'b1, 1'b0}, 5'b10110,
                8'h44, 2'h0, 8'h0A, 8'h16};
    repeat (4) @(posedge sys_clk);
    #1;
    chk({tail_tag_en_r, queue_split_r, local_loop_r, remote_loop_r, queue_sel_r}, 32'h0);
    chk(rdata_r, 32'h0);
    chk({fabric_ingress_r, pin_egress_r}, 32'h0);
    rstn <= 1'b1;
    rd(ADDR_PORT_OPERATION_CONTROL, p, m);
    chk(p, 8'h00);
    foreach (rows[i]) begin
      phy_res_i <= rows[i].phy;
      mac_cfg_i <= rows[i].mac;
      egress_prio_i <= rows[i].prio;
      wr(ADDR_PORT_OPERATION_CONTROL, rows[i].wv);
      rd(ADDR_PORT_OPERATION_CONTROL, p, m);
      chk(p, rows[i].ec);
      chk(m, rows[i].ec);
      rd(ADDR_PORT_LINK_STATUS, p, m);
      chk(p, rows[i].esp);
      chk(m, rows[i].esm);
      chk({tail_tag_en_r, queue_split_r}, {rows[i].ec[2], rows[i].ec[1:0]});
      chk({local_loop_r, remote_loop_r}, rows[i].ec[7:6]);
      chk(queue_sel_r, rows[i].eq);
    end
    wr(ADDR_PORT_LINK_STATUS, 8'hFF);
    wr(16'h0040, 8'hFF);
    wr(16'h0021, 8'hFF);
    rd(ADDR_PORT_LINK_STATUS, p, m);
    chk(p, 8'h0A);
    chk(m, 8'h16);
    rd(ADDR_PORT_OPERATION_CONTROL, p, m);
    chk(p, 8'h44);
    rd(16'h0040, p, m);
    chk(p, 8'h00);
    @(posedge sys_clk);
    #1;
    chk(rdata_r, 8'h00);
    path(8'h00, nil_b, fab_b, pin_b, nil_b);
    path(8'h80, fab_b, nil_b, nil_b, nil_b);
    path(8'h40, nil_b, nil_b, nil_b, pin_b);
    path(8'hC0, fab_b, nil_b, nil_b, pin_b);
    @(posedge sys_clk);
    rstn <= 1'b0;
    #1;
    chk({tail_tag_en_r, local_loop_r, remote_loop_r, queue_split_r}, 32'h0);
    @(posedge sys_clk);
    #1;
    rstn <= 1'b1;
    rd(ADDR_PORT_OPERATION_CONTROL, p, m);
    chk(p, 8'h00);
    stop_test;
  end
endmodule
